// ===== hw/ssap_regs.svh
// constants for the standby, switch, busy/sync and alarm pin logic
`ifndef SSAP_REGS_SVH
`define SSAP_REGS_SVH

// register port offsets (4-bit address)
`define SSAP_ADDR_STATUS     4'h0
`define SSAP_ADDR_CONFIG     4'h1
`define SSAP_ADDR_STEP_MODE  4'h2
`define SSAP_ADDR_ALARM_EN   4'h3
`define SSAP_ADDR_ADC_OUT    4'h4
`define SSAP_ADDR_COMMAND    4'h5

// status bit positions
`define SSAP_ST_BRIDGE_OFF   0
`define SSAP_ST_BUSY         1
`define SSAP_ST_SW_STATE     2
`define SSAP_ST_SW_EVENT     3
`define SSAP_ST_WRONG_CMD    4
`define SSAP_ST_NOPERF_CMD   5
`define SSAP_ST_SUPPLY_UNDERVOLTAGE_FLAG_N       6
`define SSAP_ST_THWRN_N      7
`define SSAP_ST_THSD_N       8
`define SSAP_ST_OCD_N        9

// config bit positions
`define SSAP_CFG_SWITCH_MODE_BIT     0
`define SSAP_CFG_TQREG       1

// step mode fields
`define SSAP_SM_SYNC_EN      7
`define SSAP_SM_SYNC_SEL_HI  6
`define SSAP_SM_SYNC_SEL_LO  4
`define SSAP_SM_STEP_SEL_HI  2
`define SSAP_SM_STEP_SEL_LO  0

// alarm enable bit positions
`define SSAP_AL_OCD          0
`define SSAP_AL_THWRN        1
`define SSAP_AL_THSD         2
`define SSAP_AL_SUPPLY_UNDERVOLTAGE_FLAG         3
`define SSAP_AL_SWITCH_EVENT_FLAG       4
`define SSAP_AL_WRONG        5
`define SSAP_AL_NOPERF       6
`define SSAP_AL_RESET        7

// reset values
`define SSAP_CONFIG_RST      16'h0000
`define SSAP_STEP_MODE_RST   8'h07
`define SSAP_ALARM_EN_RST    8'hFF

// command codes on the command register
`define SSAP_CMD_STATUS_READ 8'hD0
`define SSAP_CMD_IMM_STOP    8'hB8
`define SSAP_CMD_DEC_STOP    8'hB0
`define SSAP_CMD_RUN         8'h50
`define SSAP_CMD_MOVE        8'h40
`define SSAP_CMD_GOTO        8'h60
`define SSAP_CMD_IMM_HIZ     8'hA8

// converter sampling period in system clocks
`define SSAP_ADC_PERIOD      10'd512
`define SSAP_ADC_CNT_W       10
`define SSAP_ADC_LAST        10'h1FF

`endif

// ===== hw/ssap_pkg.sv
// types for the standby, switch, busy/sync and alarm pin logic
package ssap_pkg;

   typedef enum logic [1:0] {
      SSAP_IDLE,
      SSAP_MOVING,
      SSAP_STOPPED
   } ssap_motion_t;

   typedef struct packed {
      logic ocd;
      logic th_wrn;
      logic th_sd;
      logic supply_undervoltage_flag;
   } ssap_prot_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ssap_bus_t;

endpackage

// ===== hw/ssap_sync_gen.sv
// step-clock generator for the sync mode of the busy/sync pin
`timescale 1ns/1ns
module ssap_sync_gen
   import ssap_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       srst_i,
   input  wire logic       step_i,
   input  wire logic [2:0] sync_sel_i,
   input  wire logic [2:0] step_sel_i,
   output logic            sync_o
);
   logic [7:0] ustep_q;
   logic [3:0] shift;

   // sync toggles every 2^(step_sel-sync_sel) microsteps, at least every step
   always_comb begin
      if ({1'b0, step_sel_i} >= {1'b0, sync_sel_i})
         shift = 4'({1'b0, step_sel_i} - {1'b0, sync_sel_i});
      else
         shift = 4'h0;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i)
         ustep_q <= 8'h00;
      else if (step_i)
         ustep_q <= ustep_q + 8'h01;
   end

   assign sync_o = ustep_q[shift[2:0]];

endmodule // ssap_sync_gen

// ===== hw/ssap_top.sv
// standby, home switch, busy/sync, alarm and converter pacing logic
`timescale 1ns/1ns
`include "ssap_regs.svh"

// Functional notes
// - standby low: bridges off, charge pump stopped, bus and logic disabled
// - standby returns registers to defaults and disables protections
// - after standby bridges stay off; any motion command enables them
// - switch state bit: 0 open, 1 closed, refreshed every clock
// - switch falling edge sets event flag; only status read clears it
// - switch mode 0 stops motor on turn-on; mode 1 only reports
// - converter samples every 512 clocks into result register
// - converter result drives current amplitude or stays for software
// - busy/sync is open drain, busy or sync by sync-enable bit
// - busy mode: pin low while motion command runs, released at target
// - status busy flag mirrors the busy/sync pin level, so it shows the sync level in sync mode
// - sync mode: step clock from sync and step select fields
// - alarm pin low on reset exit, faults, switch event, bad commands
// - alarm mask bit per condition gates only the alarm pin
// - any logic reset forces undervoltage flag active low
module ssap_top
   import ssap_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic        standby_reset_pin_n_i,
   input  wire logic        home_contact_input_i,
   input  wire logic [7:0]  converter_input_i,
   input  wire logic        conv_done_i,
   input  wire logic        motion_done_i,
   input  wire logic        step_i,
   input  wire logic        wrong_cmd_i,
   input  wire logic        noperf_cmd_i,
   input  wire ssap_prot_t  prot_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [15:0]      rdata_o,
   output logic             bridge_en_o,
   output logic             charge_pump_en_o,
   output logic             prot_en_o,
   output logic             hard_stop_o,
   output logic             conv_start_o,
   output logic             torque_from_adc_o,
   output logic [7:0]       torque_adc_o,
   output logic             busy_sync_oe_o,
   output logic             busy_sync_out_o,
   output logic             alarm_oe_o,
   output logic             alarm_out_o
);

   ////////////////////////////////////////////////////////////////////////////
   logic         lrst;
   ssap_bus_t    bus;
   logic [15:0]  config_q;
   logic [7:0]   step_mode_q;
   logic [7:0]   alarm_en_q;
   logic [7:0]   adc_out_q;
   logic [`SSAP_ADC_CNT_W-1:0] adc_cnt_q;
   logic         bridge_off_q;
   logic         sw_state_q;
   logic         sw_prev_q;
   logic         sw_event_q;
   logic         wrong_q;
   logic         noperf_q;
   logic         reset_alarm_q;
   ssap_prot_t   prot_n_q;
   ssap_motion_t motion_q;
   logic         busy_q;
   logic         sync_lvl;
   logic         cmd_wr;
   logic         status_rd;
   logic         motion_cmd;
   logic         stop_cmd;
   logic         sw_fall;
   logic         sw_stop;
   logic         alarm_any;

   // standby pin acts as a logic reset alongside the system reset
   assign lrst = srst_i | ~standby_reset_pin_n_i;

   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   function automatic logic is_motion(input logic [7:0] c);
      is_motion = (c == `SSAP_CMD_RUN) || (c == `SSAP_CMD_MOVE) || (c == `SSAP_CMD_GOTO);
   endfunction

   assign cmd_wr     = bus.wr && (bus.addr == `SSAP_ADDR_COMMAND);
   assign status_rd  = (cmd_wr && (bus.wdata[7:0] == `SSAP_CMD_STATUS_READ)) ||
                       (bus.rd && (bus.addr == `SSAP_ADDR_STATUS));
   assign stop_cmd   = cmd_wr && ((bus.wdata[7:0] == `SSAP_CMD_IMM_STOP) ||
                                  (bus.wdata[7:0] == `SSAP_CMD_DEC_STOP));
   assign motion_cmd = cmd_wr && (is_motion(bus.wdata[7:0]) || stop_cmd);
   assign sw_fall    = sw_prev_q && !home_contact_input_i;
   assign sw_stop    = sw_fall && !config_q[`SSAP_CFG_SWITCH_MODE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         config_q    <= `SSAP_CONFIG_RST;
         step_mode_q <= `SSAP_STEP_MODE_RST;
         alarm_en_q  <= `SSAP_ALARM_EN_RST;
      end else if (bus.wr) begin
         case (bus.addr)
            `SSAP_ADDR_CONFIG:    config_q    <= bus.wdata;
            `SSAP_ADDR_STEP_MODE: step_mode_q <= bus.wdata[7:0];
            `SSAP_ADDR_ALARM_EN:  alarm_en_q  <= bus.wdata[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bridge state: off after reset, any motion command turns it on
   always_ff @(posedge sys_clk_i) begin
      if (lrst)
         bridge_off_q <= 1'b1;
      else if (!prot_n_q.th_sd || !prot_n_q.ocd)
         bridge_off_q <= 1'b1;
      else if (cmd_wr && (bus.wdata[7:0] == `SSAP_CMD_IMM_HIZ))
         bridge_off_q <= 1'b1;
      else if (motion_cmd)
         bridge_off_q <= 1'b0;
   end

   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         bridge_en_o      <= 1'b0;
         charge_pump_en_o <= 1'b0;
         prot_en_o        <= 1'b0;
      end else begin
         bridge_en_o      <= !bridge_off_q;
         charge_pump_en_o <= 1'b1;
         prot_en_o        <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // home switch sampling, edge detect, event flag
   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         sw_prev_q  <= 1'b1;
         sw_state_q <= 1'b0;
      end else begin
         sw_prev_q  <= home_contact_input_i;
         sw_state_q <= !home_contact_input_i;
      end
   end

   // set wins over the status-read clear
   always_ff @(posedge sys_clk_i) begin
      if (lrst)
         sw_event_q <= 1'b0;
      else if (sw_fall)
         sw_event_q <= 1'b1;
      else if (status_rd)
         sw_event_q <= 1'b0;
   end

   always_ff @(posedge sys_clk_i) begin
      if (lrst)
         hard_stop_o <= 1'b0;
      else
         hard_stop_o <= sw_stop;
   end

   ////////////////////////////////////////////////////////////////////////////
   // command error flags and power-up alarm
   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         wrong_q       <= 1'b0;
         noperf_q      <= 1'b0;
         reset_alarm_q <= 1'b1;
      end else begin
         if (wrong_cmd_i)
            wrong_q <= 1'b1;
         else if (status_rd)
            wrong_q <= 1'b0;
         if (noperf_cmd_i)
            noperf_q <= 1'b1;
         else if (status_rd)
            noperf_q <= 1'b0;
         if (status_rd)
            reset_alarm_q <= 1'b0;
      end
   end

   // active-low protection flags, held until cause gone and status read
   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         prot_n_q.ocd    <= 1'b1;
         prot_n_q.th_wrn <= 1'b1;
         prot_n_q.th_sd  <= 1'b1;
         prot_n_q.supply_undervoltage_flag   <= 1'b0;
      end else begin
         if (prot_i.ocd)
            prot_n_q.ocd <= 1'b0;
         else if (status_rd)
            prot_n_q.ocd <= 1'b1;
         if (prot_i.th_wrn)
            prot_n_q.th_wrn <= 1'b0;
         else if (status_rd)
            prot_n_q.th_wrn <= 1'b1;
         if (prot_i.th_sd)
            prot_n_q.th_sd <= 1'b0;
         else if (status_rd)
            prot_n_q.th_sd <= 1'b1;
         if (prot_i.supply_undervoltage_flag)
            prot_n_q.supply_undervoltage_flag <= 1'b0;
         else if (status_rd)
            prot_n_q.supply_undervoltage_flag <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // motion tracking for busy
   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         motion_q <= SSAP_IDLE;
      end else begin
         case (motion_q)
            SSAP_IDLE, SSAP_STOPPED:
               if (cmd_wr && is_motion(bus.wdata[7:0]) && prot_n_q.supply_undervoltage_flag)
                  motion_q <= SSAP_MOVING;
            SSAP_MOVING:
               if (motion_done_i || sw_stop || stop_cmd)
                  motion_q <= SSAP_STOPPED;
            default:
               motion_q <= SSAP_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (lrst)
         busy_q <= 1'b0;
      else
         busy_q <= (motion_q == SSAP_MOVING);
   end

   ssap_sync_gen u_sync_gen (
      .sys_clk_i  (sys_clk_i),
      .srst_i     (lrst),
      .step_i     (step_i),
      .sync_sel_i (step_mode_q[`SSAP_SM_SYNC_SEL_HI:`SSAP_SM_SYNC_SEL_LO]),
      .step_sel_i (step_mode_q[`SSAP_SM_STEP_SEL_HI:`SSAP_SM_STEP_SEL_LO]),
      .sync_o     (sync_lvl)
   );

   // open drain: enable high pulls the pin low
   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         busy_sync_oe_o  <= 1'b0;
         busy_sync_out_o <= 1'b0;
      end else begin
         busy_sync_out_o <= 1'b0;
         if (step_mode_q[`SSAP_SM_SYNC_EN])
            busy_sync_oe_o <= !sync_lvl;
         else
            busy_sync_oe_o <= busy_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // converter pacing and result
   always_ff @(posedge sys_clk_i) begin
      if (lrst)
         adc_cnt_q <= '0;
      else if (adc_cnt_q == `SSAP_ADC_LAST)
         adc_cnt_q <= '0;
      else
         adc_cnt_q <= adc_cnt_q + `SSAP_ADC_CNT_W'(1);
   end

   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         conv_start_o <= 1'b0;
         adc_out_q    <= 8'h00;
      end else begin
         conv_start_o <= (adc_cnt_q == `SSAP_ADC_LAST);
         if (conv_done_i)
            adc_out_q <= converter_input_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         torque_from_adc_o <= 1'b0;
         torque_adc_o      <= 8'h00;
      end else begin
         torque_from_adc_o <= config_q[`SSAP_CFG_TQREG];
         torque_adc_o      <= adc_out_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // alarm: latched conditions gated by mask
   assign alarm_any = (alarm_en_q[`SSAP_AL_OCD]    && !prot_n_q.ocd)    ||
                      (alarm_en_q[`SSAP_AL_THWRN]  && !prot_n_q.th_wrn) ||
                      (alarm_en_q[`SSAP_AL_THSD]   && !prot_n_q.th_sd)  ||
                      (alarm_en_q[`SSAP_AL_SUPPLY_UNDERVOLTAGE_FLAG]   && !prot_n_q.supply_undervoltage_flag)   ||
                      (alarm_en_q[`SSAP_AL_SWITCH_EVENT_FLAG] && sw_event_q)       ||
                      (alarm_en_q[`SSAP_AL_WRONG]  && wrong_q)          ||
                      (alarm_en_q[`SSAP_AL_NOPERF] && noperf_q)         ||
                      (alarm_en_q[`SSAP_AL_RESET]  && reset_alarm_q);

   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         alarm_oe_o  <= 1'b0;
         alarm_out_o <= 1'b0;
      end else begin
         alarm_oe_o  <= alarm_any;
         alarm_out_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after strobe
   always_ff @(posedge sys_clk_i) begin
      if (lrst) begin
         rdata_o <= 16'h0000;
      end else if (bus.rd) begin
         case (bus.addr)
            `SSAP_ADDR_STATUS: begin
               rdata_o                        <= 16'h0000;
               rdata_o[`SSAP_ST_BRIDGE_OFF]   <= bridge_off_q;
               rdata_o[`SSAP_ST_BUSY]         <= !busy_sync_oe_o;
               rdata_o[`SSAP_ST_SW_STATE]     <= sw_state_q;
               rdata_o[`SSAP_ST_SW_EVENT]     <= sw_event_q;
               rdata_o[`SSAP_ST_WRONG_CMD]    <= wrong_q;
               rdata_o[`SSAP_ST_NOPERF_CMD]   <= noperf_q;
               rdata_o[`SSAP_ST_SUPPLY_UNDERVOLTAGE_FLAG_N]       <= prot_n_q.supply_undervoltage_flag;
               rdata_o[`SSAP_ST_THWRN_N]      <= prot_n_q.th_wrn;
               rdata_o[`SSAP_ST_THSD_N]       <= prot_n_q.th_sd;
               rdata_o[`SSAP_ST_OCD_N]        <= prot_n_q.ocd;
            end
            `SSAP_ADDR_CONFIG:    rdata_o <= config_q;
            `SSAP_ADDR_STEP_MODE: rdata_o <= {8'h00, step_mode_q};
            `SSAP_ADDR_ALARM_EN:  rdata_o <= {8'h00, alarm_en_q};
            `SSAP_ADDR_ADC_OUT:   rdata_o <= {8'h00, adc_out_q};
            default:              rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

endmodule // ssap_top

// ===== testbench/ssap_top_properties.sv
// concurrent checks on the standby, switch, converter and pin outputs
`timescale 1ns/1ns
`include "ssap_regs.svh"
module ssap_top_properties
   import ssap_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic        standby_reset_pin_n_i,
   input  wire logic        home_contact_input_i,
   input  wire logic [7:0]  converter_input_i,
   input  wire logic        conv_done_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        bridge_en_o,
   input  wire logic        charge_pump_en_o,
   input  wire logic        prot_en_o,
   input  wire logic        hard_stop_o,
   input  wire logic        conv_start_o,
   input  wire logic [7:0]  torque_adc_o,
   input  wire logic        busy_sync_out_o,
   input  wire logic        alarm_oe_o,
   input  wire logic        alarm_out_o
);
   logic [9:0] gap_q;
   logic       seen_q;

   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   ////////////////////////////////////////////////////////////////
   // cycles since the last converter start; unknown phase until one seen
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !standby_reset_pin_n_i) begin
         gap_q  <= 10'h000;
         seen_q <= 1'h0;
      end else if (conv_start_o) begin
         gap_q  <= 10'h000;
         seen_q <= 1'h1;
      end else begin
         gap_q  <= gap_q + 10'h001;
      end
   end

   sequence s_release;
      $rose(standby_reset_pin_n_i) || $fell(srst_i);
   endsequence

   sequence s_motion_cmd;
      wr_i && addr_i == `SSAP_ADDR_COMMAND && wdata_i[7:0] inside {`SSAP_CMD_RUN, `SSAP_CMD_MOVE,
         `SSAP_CMD_GOTO, `SSAP_CMD_IMM_STOP, `SSAP_CMD_DEC_STOP};
   endsequence

   ////////////////////////////////////////////////////////////////
   a_standby_off: assert property (!standby_reset_pin_n_i |=> !bridge_en_o && !charge_pump_en_o && !prot_en_o)
      else $error("bridge, pump or protection active in standby");
   a_release_bridge_off: assert property (s_release |-> !bridge_en_o [*4])
      else $error("bridges driven right after reset exit");
   a_release_alarm: assert property (s_release |-> ##[1:3] alarm_oe_o)
      else $error("alarm not raised after reset exit");
   a_motion_bridge_on: assert property (s_motion_cmd |-> ##[1:4] bridge_en_o)
      else $error("motion command left bridges off");
   a_conv_period: assert property (conv_start_o && seen_q |-> gap_q == 10'h1FF)
      else $error("converter start spacing wrong");
   a_conv_bound: assert property (seen_q |-> gap_q < 10'h200)
      else $error("converter start missing");
   a_torque_follow: assert property (conv_done_i |-> ##2 torque_adc_o == $past(converter_input_i, 2))
      else $error("converter result not forwarded");
   a_stop_cause: assert property (hard_stop_o |-> !$past(home_contact_input_i))
      else $error("stop without closed switch");
   a_stop_once: assert property (hard_stop_o |=> !hard_stop_o)
      else $error("stop pulse longer than one cycle");
   a_open_drain: assert property (!busy_sync_out_o && !alarm_out_o)
      else $error("open drain pin driven high");
endmodule // ssap_top_properties

bind ssap_top ssap_top_properties i_ssap_top_properties (
   .sys_clk_i, .srst_i, .standby_reset_pin_n_i, .home_contact_input_i, .converter_input_i,
   .conv_done_i, .addr_i, .wdata_i, .wr_i, .bridge_en_o, .charge_pump_en_o, .prot_en_o,
   .hard_stop_o, .conv_start_o, .torque_adc_o, .busy_sync_out_o, .alarm_oe_o, .alarm_out_o
);

// ===== testbench/ssap_host.sv
// host model: register port master and standby pin driver
`timescale 1ns/1ns
`include "ssap_regs.svh"
module ssap_host
   import ssap_pkg::*;
#(
   parameter int STBY_MIN = 4,
   parameter int WAKE     = 8
)(
   input  wire logic        sys_clk_i,
   input  wire logic [15:0] rdata_i,
   output logic             standby_reset_pin_n_o,
   output logic [3:0]       addr_o,
   output logic [15:0]      wdata_o,
   output logic             wr_o,
   output logic             rd_o
);
   initial begin
      standby_reset_pin_n_o = 1'h1;
      addr_o                = 4'h0;
      wdata_o               = 16'h0000;
      wr_o                  = 1'h0;
      rd_o                  = 1'h0;
   end

   task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'h1;
      @(posedge sys_clk_i);
      wr_o    <= 1'h0;
   endtask

   // data stand only in the cycle after the strobe
   task automatic bus_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk_i);
      addr_o <= a;
      rd_o   <= 1'h1;
      @(posedge sys_clk_i);
      rd_o   <= 1'h0;
      @(posedge sys_clk_i);
      d = rdata_i;
   endtask

   task automatic standby_cycle();
      bus_write(`SSAP_ADDR_COMMAND, {8'h00, `SSAP_CMD_IMM_HIZ});
      @(posedge sys_clk_i);
      standby_reset_pin_n_o <= 1'h0;
      repeat (STBY_MIN) @(posedge sys_clk_i);
      standby_reset_pin_n_o <= 1'h1;
      repeat (WAKE) @(posedge sys_clk_i);
   endtask
endmodule // ssap_host

// ===== testbench/ssap_top_bench.sv
// self-checking bench for the standby, switch, busy/sync and alarm logic
`timescale 1ns/1ns
`include "ssap_regs.svh"
module ssap_top_bench;
   import ssap_pkg::*;
   logic        sys_clk_i = 1'h0;
   logic        srst_i, standby_reset_pin_n_i, home_contact_input_i, conv_done_i, motion_done_i;
   logic        step_i, wrong_cmd_i, noperf_cmd_i, wr_i, rd_i, bridge_en_o, charge_pump_en_o;
   logic        prot_en_o, hard_stop_o, conv_start_o, torque_from_adc_o, busy_sync_oe_o;
   logic        busy_sync_out_o, alarm_oe_o, alarm_out_o;
   logic [7:0]  converter_input_i, torque_adc_o;
   logic [3:0]  addr_i;
   logic [15:0] wdata_i, rdata_o;
   ssap_prot_t  prot_i;
   int          errors, total_checks, cycles, stops, gap, last_cs;

   always #50 sys_clk_i = ~sys_clk_i;

   ssap_top i_ssap_top (
      .sys_clk_i, .srst_i, .standby_reset_pin_n_i, .home_contact_input_i, .converter_input_i,
      .conv_done_i, .motion_done_i, .step_i, .wrong_cmd_i, .noperf_cmd_i, .prot_i, .addr_i,
      .wdata_i, .wr_i, .rd_i, .rdata_o, .bridge_en_o, .charge_pump_en_o, .prot_en_o, .hard_stop_o,
      .conv_start_o, .torque_from_adc_o, .torque_adc_o, .busy_sync_oe_o, .busy_sync_out_o,
      .alarm_oe_o, .alarm_out_o
   );
   ssap_host i_ssap_host (
      .sys_clk_i, .rdata_i(rdata_o), .standby_reset_pin_n_o(standby_reset_pin_n_i),
      .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i)
   );

   ////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // stop pulses, converter start spacing and hang guard
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (hard_stop_o === 1'h1) stops <= stops + 1;
      if (conv_start_o === 1'h1) begin
         if (last_cs > 0) gap <= cycles - last_cs;
         last_cs <= cycles;
      end
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_ssap_host.bus_write(a, d);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] v;
      i_ssap_host.bus_read(a, v);
      chk16(v, e);
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic t_reset_state();
      chk1(alarm_oe_o, 1'h1);
      chk1(charge_pump_en_o, 1'h1);
      rd_chk(`SSAP_ADDR_CONFIG, `SSAP_CONFIG_RST);
      rd_chk(`SSAP_ADDR_STEP_MODE, {8'h00, `SSAP_STEP_MODE_RST});
      rd_chk(`SSAP_ADDR_ALARM_EN, {8'h00, `SSAP_ALARM_EN_RST});
      rd_chk(4'hF, 16'h0000);
      rd_chk(`SSAP_ADDR_STATUS, 16'h0383);
      rd_chk(`SSAP_ADDR_STATUS, 16'h03C3);
      wait_clk(3);
      chk1(alarm_oe_o, 1'h0);
   endtask

   task automatic t_switch();
      @(posedge sys_clk_i) home_contact_input_i <= 1'h0;
      wait_clk(4);
      chk16(16'(stops), 16'h0001);
      chk1(alarm_oe_o, 1'h1);
      rd_chk(`SSAP_ADDR_STATUS, 16'h03CF);
      rd_chk(`SSAP_ADDR_STATUS, 16'h03C7);
      @(posedge sys_clk_i) home_contact_input_i <= 1'h1;
      wr(`SSAP_ADDR_CONFIG, 16'h0001);
      wr(`SSAP_ADDR_ALARM_EN, 16'h00EF);
      @(posedge sys_clk_i) home_contact_input_i <= 1'h0;
      wait_clk(4);
      chk16(16'(stops), 16'h0001);
      chk1(alarm_oe_o, 1'h0);
      rd_chk(`SSAP_ADDR_STATUS, 16'h03CF);
      wr(`SSAP_ADDR_CONFIG, 16'h0000);
      wr(`SSAP_ADDR_ALARM_EN, 16'h00FF);
      @(posedge sys_clk_i) home_contact_input_i <= 1'h1;
      wait_clk(3);
   endtask

   task automatic t_faults();
      logic [15:0] tbl [6] = '{16'h0200, 16'h0080, 16'h0100, 16'h0040, 16'h0010, 16'h0020};
      logic [15:0] v;
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk_i);
         if (i < 4) prot_i <= ssap_prot_t'(4'h8 >> i);
         wrong_cmd_i  <= (i == 4);
         noperf_cmd_i <= (i == 5);
         @(posedge sys_clk_i);
         wrong_cmd_i  <= 1'h0;
         noperf_cmd_i <= 1'h0;
         wait_clk(3);
         chk1(alarm_oe_o, 1'h1);
         rd_chk(`SSAP_ADDR_STATUS, 16'h03C3 ^ tbl[i]);
         @(posedge sys_clk_i) prot_i <= '0;
         wait_clk(2);
         i_ssap_host.bus_read(`SSAP_ADDR_STATUS, v);
         wait_clk(3);
         chk1(alarm_oe_o, 1'h0);
      end
   endtask

   task automatic t_conv();
      for (int k = 0; k < 1100 && gap == 0; k++) @(posedge sys_clk_i);
      chk16(16'(gap), 16'h0200);
      @(posedge sys_clk_i);
      converter_input_i <= 8'h5A;
      conv_done_i       <= 1'h1;
      @(posedge sys_clk_i) conv_done_i <= 1'h0;
      rd_chk(`SSAP_ADDR_ADC_OUT, 16'h005A);
      wr(`SSAP_ADDR_CONFIG, 16'h0002);
      wait_clk(2);
      chk1(torque_from_adc_o, 1'h1);
      chk16({8'h00, torque_adc_o}, 16'h005A);
      wr(`SSAP_ADDR_CONFIG, 16'h0000);
   endtask

   task automatic t_busy();
      logic [7:0] mv [3] = '{`SSAP_CMD_RUN, `SSAP_CMD_MOVE, `SSAP_CMD_GOTO};
      logic [7:0] st [2] = '{`SSAP_CMD_IMM_STOP, `SSAP_CMD_DEC_STOP};
      for (int i = 0; i < 3; i++) begin
         wr(`SSAP_ADDR_COMMAND, {8'h00, mv[i]});
         wait_clk(3);
         chk1(busy_sync_oe_o, 1'h1);
         rd_chk(`SSAP_ADDR_STATUS, 16'h03C0);
         @(posedge sys_clk_i) motion_done_i <= 1'h1;
         @(posedge sys_clk_i) motion_done_i <= 1'h0;
         wait_clk(3);
         chk1(busy_sync_oe_o, 1'h0);
         rd_chk(`SSAP_ADDR_STATUS, 16'h03C2);
      end
      for (int i = 0; i < 2; i++) begin
         wr(`SSAP_ADDR_COMMAND, {8'h00, `SSAP_CMD_IMM_HIZ});
         wait_clk(3);
         chk1(bridge_en_o, 1'h0);
         wr(`SSAP_ADDR_COMMAND, {8'h00, st[i]});
         wait_clk(3);
         chk1(bridge_en_o, 1'h1);
      end
   endtask

   // step select equal to sync select: pin follows the lowest step bit
   task automatic t_sync();
      logic prev;
      wr(`SSAP_ADDR_STEP_MODE, 16'h0080);
      // let the pin settle on the sync level before taking a reference
      wait_clk(2);
      for (int i = 0; i < 4; i++) begin
         prev = busy_sync_oe_o;
         @(posedge sys_clk_i) step_i <= 1'h1;
         @(posedge sys_clk_i) step_i <= 1'h0;
         wait_clk(3);
         chk1(busy_sync_oe_o, ~prev);
      end
      wr(`SSAP_ADDR_STEP_MODE, 16'h0007);
   endtask

   task automatic t_standby();
      wr(`SSAP_ADDR_CONFIG, 16'h0003);
      i_ssap_host.standby_cycle();
      chk1(bridge_en_o, 1'h0);
      chk1(alarm_oe_o, 1'h1);
      rd_chk(`SSAP_ADDR_CONFIG, 16'h0000);
      rd_chk(`SSAP_ADDR_STATUS, 16'h0383);
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      srst_i               = 1'h1;
      home_contact_input_i = 1'h1;
      converter_input_i    = 8'h00;
      conv_done_i          = 1'h0;
      motion_done_i        = 1'h0;
      step_i               = 1'h0;
      wrong_cmd_i          = 1'h0;
      noperf_cmd_i         = 1'h0;
      prot_i               = '0;
      repeat (5) @(posedge sys_clk_i);
      srst_i <= 1'h0;
      wait_clk(8);
      t_reset_state();
      t_switch();
      t_faults();
      t_conv();
      t_busy();
      t_sync();
      t_standby();
      wrap_up();
   end
endmodule // ssap_top_bench
